// file: tb_microcode_sequencer_decoder.sv
// self-checking bench for the microcode sequencer and decoder
module tb_microcode_sequencer_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk;
  logic        srst;
  logic [4:0]  io_req;
  logic [3:0]  cond;
  logic [11:0] paddr;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [31:0] pwdata, prdata, q;
  logic        e;
  logic [11:0] next_uaddr;
  logic [1:0]  phase;
  logic [2:0]  click;
  logic        emu_task, running, y_io, z_io, carry_in, ureg_en, mem_op;
  logic [7:0]  alu_lo, alu_hi, const_byte;
  logic [15:0] x_cmd;
  logic [3:0]  y_norm, z_norm;
  int          miscompares;
  int          samples_checked;
  localparam logic [47:0] W_LOOP = 48'h0236_590a_1500;
  ////////////////////////////////////////////////////////////////////////////////
  useq_top #(.DEPTH(useq_pkg::CS_DEPTH)) DUT (
    .i_clk(clk), .i_srst(srst), .i_paddr(paddr), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_io_req(io_req), .i_cond(cond), .o_next_uaddr(next_uaddr),
    .o_phase(phase), .o_click(click), .o_emu_task(emu_task), .o_running(running),
    .o_alu_lo(alu_lo), .o_alu_hi(alu_hi), .o_x_cmd(x_cmd), .o_y_normal_func(y_norm),
    .o_z_normal_func(z_norm), .o_y_io_output_sel(y_io), .o_z_io_input_sel(z_io),
    .o_const_byte(const_byte), .o_carry_in(carry_in), .o_uregister_enable(ureg_en),
    .o_mem_op(mem_op)
  );
  useq_host_model u_host (
    .i_clk(clk), .i_prdata(prdata), .i_pready(pready), .i_pslverr(pslverr),
    .o_paddr(paddr), .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite),
    .o_pwdata(pwdata)
  );
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_load_read();
    int i;
    u_host.load(12'h010, 48'h0110_0010_0000);
    u_host.load(12'h011, 48'h0200_0000_0000);
    u_host.load(12'h023, W_LOOP);
    u_host.xfer(1'b1, useq_pkg::REG_PC, 32'h0000_0023, q, e);
    @(posedge clk);
    #1;
    chk("preset next address", 32'h023, next_uaddr);
    for (i = 0; i < 7; i++) begin
      u_host.xfer(1'b0, useq_pkg::REG_RBYTE, 32'h0, q, e);
      chk("read byte", (W_LOOP >> (8 * (i % 6))) & 48'hff, q);
    end
    u_host.xfer(1'b0, 12'h01c, 32'h0, q, e);
    chk("unmapped error", 32'h1, e);
    u_host.xfer(1'b0, useq_pkg::REG_STAT, 32'h0, q, e);
    chk("status halted", 32'h0, q[0]);
    $display("test load_read done");
  endtask
  task automatic t_run();
    int last_ph, last_ck, gap, seen;
    io_req <= 5'b00100;
    cond <= 4'h3;
    u_host.xfer(1'b1, useq_pkg::REG_COND, 32'h0, q, e);
    u_host.xfer(1'b1, useq_pkg::REG_PC, 32'h0000_0010, q, e);
    u_host.xfer(1'b1, useq_pkg::REG_CTRL, 32'h0000_0001, q, e);
    #1;
    last_ph = phase;
    last_ck = click;
    gap = 0;
    seen = 0;
    repeat (300) begin
      @(posedge clk);
      #1;
      gap++;
      if (phase !== last_ph[1:0]) begin
        chk("phase step", (last_ph + 1) % 3, phase);
        chk("click step", last_ph == 2 ? (last_ck + 1) % 5 : last_ck, click);
        if (seen > 0) chk("cycle clocks", useq_pkg::CYCLE_CLKS, gap);
        seen++;
        gap = 0;
        last_ph = phase;
        last_ck = click;
      end
      if (phase === 2'd1) chk("emulator task", !io_req[click], emu_task);
    end
    chk("enough cycles", 32'h1, seen >= 20);
    chk("running", 32'h1, running);
    chk("branch target", 32'h023, next_uaddr);
    chk("carry in", 32'h1, carry_in);
    chk("memory op", 32'h1, mem_op);
    chk("uregister enable", 32'h0, ureg_en);
    chk("x command", 32'h0200, x_cmd);
    chk("y normal", 32'h5, y_norm);
    chk("z normal", 32'h6, z_norm);
    chk("y io select", 32'h0, y_io);
    chk("z io select", 32'h0, z_io);
    chk("constant byte", 32'h0, const_byte);
    chk("alu low half", 32'ha8, alu_lo);
    chk("alu high half", 32'ha9, alu_hi);
    u_host.xfer(1'b1, useq_pkg::REG_PC, 32'h0, q, e);
    repeat (40) @(posedge clk);
    #1;
    chk("pc write refused", 32'h023, next_uaddr);
    $display("test run done");
  endtask
  task automatic t_stop();
    u_host.xfer(1'b1, useq_pkg::REG_CTRL, 32'h0, q, e);
    repeat (30) @(posedge clk);
    #1;
    chk("stopped", 32'h0, running);
    chk("held address", 32'h023, next_uaddr);
    chk("mem op quiet", 32'h0, mem_op);
    chk("x command quiet", 32'h0, x_cmd);
    $display("test stop done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    miscompares = 0;
    samples_checked = 0;
    srst = 1'b1;
    io_req = 5'h00;
    cond = 4'h0;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    #1;
    chk("reset running", 32'h0, running);
    chk("reset phase", 32'h0, phase);
    chk("reset click", 32'h0, click);
    chk("reset emulator", 32'h1, emu_task);
    t_load_read();
    t_run();
    t_stop();
    conclude();
  end
  // cuts a hang short; the whole run needs well under a tenth of this
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    conclude();
  end
endmodule

// file: useq_dec_if.sv
// interface: look-ahead decoder to sequencer command bundle
interface useq_dec_if;
  logic [3:0]  sel;
  logic [3:0]  fx;
  logic [3:0]  fy;
  logic [3:0]  fz;
  logic        y_branch_dispatch;
  logic        y_io_output_sel;
  logic        z_io_input_sel;
  logic [7:0]  const_byte;
  logic [15:0] x_cmd;
  logic [3:0]  y_normal_func;
  logic [3:0]  z_normal_func;
  modport dec (input sel, fx, fy, fz, output y_branch_dispatch, y_io_output_sel,
               z_io_input_sel, const_byte, x_cmd, y_normal_func, z_normal_func);
  modport seq (output sel, fx, fy, fz, input y_branch_dispatch, y_io_output_sel,
               z_io_input_sel, const_byte, x_cmd, y_normal_func, z_normal_func);
endinterface

// file: useq_host_model.sv
// host processor model: apb master that loads, reads and controls control store
module useq_host_model (
  input  wire logic        i_clk,
  input  wire logic [31:0] i_prdata,
  input  wire logic        i_pready,
  input  wire logic        i_pslverr,
  output logic      [11:0] o_paddr,
  output logic             o_psel,
  output logic             o_penable,
  output logic             o_pwrite,
  output logic      [31:0] o_pwdata
);
  initial begin
    o_paddr = 12'h000;
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_pwdata = 32'h0000_0000;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // one transfer, held until pready is seen high at a rising edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge i_clk);
    o_psel <= 1'b1;
    o_penable <= 1'b0;
    o_pwrite <= w;
    o_paddr <= a;
    o_pwdata <= d;
    @(posedge i_clk);
    o_penable <= 1'b1;
    // no local limit: only the bench watchdog ends a wait that never answers
    do begin
      @(posedge i_clk);
    end while (i_pready !== 1'b1);
    q = i_prdata;
    e = i_pslverr;
    o_psel <= 1'b0;
    o_penable <= 1'b0;
    // released bus shows no stale value, so a slave latching late is caught
    o_paddr <= ~a;
    o_pwdata <= ~d;
  endtask
  // word goes in high 16 bits first, then low 32 bits, then a commit
  task automatic load(input logic [11:0] a, input logic [47:0] w);
    logic [31:0] q;
    logic        e;
    xfer(1'b1, useq_pkg::REG_WADDR, {20'h0, a}, q, e);
    xfer(1'b1, useq_pkg::REG_WDATA, {16'h0, w[47:32]}, q, e);
    xfer(1'b1, useq_pkg::REG_WDATA, w[31:0], q, e);
    xfer(1'b1, useq_pkg::REG_CTRL, 32'h0000_0002, q, e);
  endtask
endmodule

// file: useq_lookahead.sv
// look-ahead decoder of selector and x, y, z function fields
module useq_lookahead (
  useq_dec_if.dec d
);
  useq_pkg::y_mode_t ym;
  useq_pkg::z_mode_t zm;
  always_comb begin
    ym = useq_pkg::y_mode_t'(d.sel[1:0]);
    zm = useq_pkg::z_mode_t'(d.sel[3:2]);
    d.y_branch_dispatch = (ym == useq_pkg::Y_BRANCH);
    d.y_io_output_sel   = (ym == useq_pkg::Y_Y_IO_OUTPUT_SEL);
    d.z_io_input_sel    = (zm == useq_pkg::Z_IOIN);
    d.y_normal_func     = (ym == useq_pkg::Y_NORM) ? d.fy : 4'h0;
    d.z_normal_func     = (zm == useq_pkg::Z_NORM) ? d.fz : 4'h0;
    d.const_byte        = {(ym == useq_pkg::Y_BYTE_HI) ? d.fy : 4'h0,
                           (zm == useq_pkg::Z_NIBBLE) ? d.fz : 4'h0};
    d.x_cmd             = 16'h0001 << d.fx;
  end
endmodule

// file: useq_pkg.sv
// package: microinstruction layout, selector modes, timing and host register map
package useq_pkg;
  localparam int WORD_W       = 48;
  localparam int ADDR_W       = 12;
  localparam int CS_DEPTH     = 4096;
  localparam int CS_MAX_DEPTH = 8192;
  localparam int CYCLE_NS     = 125;
  localparam int CLK_NS       = 10;
  localparam int CYCLE_CLKS   = (CYCLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CLICKS       = 5;
  localparam int ALU_LSB      = 0;
  localparam int ALU_W        = 16;
  localparam int CIN_BIT      = 17;
  localparam int ENU_BIT      = 18;
  localparam int MEM_BIT      = 19;
  localparam int SEL_LSB      = 20;
  localparam int FX_LSB       = 24;
  localparam int FY_LSB       = 28;
  localparam int FZ_LSB       = 32;
  localparam int GOTO_LSB     = 36;
  localparam int AS_LSB       = 8;
  localparam int AF_LSB       = 11;
  localparam logic [11:0] REG_CTRL  = 12'h000;
  localparam logic [11:0] REG_PC    = 12'h004;
  localparam logic [11:0] REG_WADDR = 12'h008;
  localparam logic [11:0] REG_WDATA = 12'h00c;
  localparam logic [11:0] REG_RBYTE = 12'h010;
  localparam logic [11:0] REG_STAT  = 12'h014;
  localparam logic [11:0] REG_COND  = 12'h018;
  localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
  typedef enum logic [1:0] {Y_NORM, Y_BRANCH, Y_Y_IO_OUTPUT_SEL, Y_BYTE_HI} y_mode_t;
  typedef enum logic [1:0] {Z_NORM, Z_UADDR, Z_IOIN, Z_NIBBLE} z_mode_t;
  typedef enum logic [1:0] {PH_ONE, PH_TWO, PH_THREE} phase_t;
endpackage

// file: useq_top.sv
// microcode sequencer and decoder with apb host access to control store
// Function
// - each microinstruction completes in one machine cycle of 13 clocks (130 ns).
// - successor word is fetched while current one executes.
// - phase counter runs one, two, three, one without skip or repeat.
// - three phases form a click; clicks 0..4 form a round.
// - emulator task runs in a click unless its io task requests.
// - control store holds up to 8K words; base is 4K by 48; the 12-bit addresses here reach only 4K words.
// - host reads only the next-address word, 8 bits per access.
// - host loads microcode, presets the pc, starts and stops.
// - words are 48 bits with a 12-bit next address.
// - alu bits 0-15, misc 16-35, goto address 36-47.
// - selector bits 0-1 choose the y field meaning.
// - selector upper bits choose the z field meaning.
// - prior branch ORs condition bits into the goto address.
// - raw latch holds all fields except goto and selector.
// - selector and function fields are decoded one cycle ahead.
// - piped goto plus branch logic feed the next-address register.
// - alu controls go separately to low and high byte halves.
module useq_top #(
  parameter int DEPTH = useq_pkg::CS_DEPTH
) (
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  input  wire logic [11:0] i_paddr,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic [4:0]  i_io_req,
  input  wire logic [3:0]  i_cond,
  output logic      [11:0] o_next_uaddr,
  output logic      [1:0]  o_phase,
  output logic      [2:0]  o_click,
  output logic             o_emu_task,
  output logic             o_running,
  output logic      [7:0]  o_alu_lo,
  output logic      [7:0]  o_alu_hi,
  output logic      [15:0] o_x_cmd,
  output logic      [3:0]  o_y_normal_func,
  output logic      [3:0]  o_z_normal_func,
  output logic             o_y_io_output_sel,
  output logic             o_z_io_input_sel,
  output logic      [7:0]  o_const_byte,
  output logic             o_carry_in,
  output logic             o_uregister_enable,
  output logic             o_mem_op
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(useq_pkg::CYCLE_CLKS);

  ////////////////////////////////////////////////////////////////////
  logic [useq_pkg::WORD_W-1:0] store [DEPTH];
  logic                        run_ff;
  logic [CW-1:0]               tick_ff;
  logic                        step;
  useq_pkg::phase_t            phase_ff;
  logic [2:0]                  click_ff;
  logic [11:0]                 next_uaddr_ff;
  logic [useq_pkg::WORD_W-1:0] fetch_ff;
  logic [35:0]                 raw_uinstr_latch_ff;
  logic [useq_pkg::WORD_W-1:0] fetch_word;
  logic [11:0]                 piped_goto_addr;
  logic [CW-1:0]               since_step_ff;
  logic                        stepped_ff;
  logic [11:0]                 next_uaddr_inputs;
  logic [11:0]                 waddr_ff;
  logic [47:0]                 wdata_ff;
  logic [3:0]                  cond_ff;
  logic [2:0]                  rbyte_idx_ff;
  logic                        acc;
  logic                        wr;
  logic                        rd;
  logic                        mapped;
  useq_dec_if                  dif ();

  assign acc    = i_psel && i_penable && o_pready;
  assign wr     = acc && i_pwrite;
  assign rd     = acc && !i_pwrite;
  assign step   = run_ff && (tick_ff == CW'(useq_pkg::CYCLE_CLKS - 1));
  assign mapped = i_paddr <= useq_pkg::REG_COND;

  ////////////////////////////////////////////////////////////////////
  // apb slave: no wait states, answer in the access cycle after setup
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_pready <= 1'b0;
    end else begin
      o_pready <= i_psel && !i_penable;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_pslverr <= 1'b0;
    end else begin
      o_pslverr <= i_psel && !i_penable && !mapped;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      run_ff <= useq_pkg::CTRL_RST[0];
    end else if (wr && i_paddr == useq_pkg::REG_CTRL) begin
      run_ff <= i_pwdata[0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      waddr_ff <= 12'h000;
      wdata_ff <= 48'h0;
      cond_ff  <= 4'h0;
    end else if (wr) begin
      unique case (i_paddr)
        useq_pkg::REG_WADDR: waddr_ff <= i_pwdata[11:0];
        useq_pkg::REG_WDATA: wdata_ff <= {wdata_ff[15:0], i_pwdata};
        useq_pkg::REG_COND:  cond_ff  <= i_pwdata[3:0];
        default: ;
      endcase
    end
  end

  // word write commits on ctrl bit 1; store is flip-flops, so depth costs area
  always_ff @(posedge i_clk) begin
    if (wr && i_paddr == useq_pkg::REG_CTRL && i_pwdata[1] && !run_ff) begin
      store[waddr_ff[AW-1:0]] <= wdata_ff;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rbyte_idx_ff <= 3'h0;
    end else if (rd && i_paddr == useq_pkg::REG_RBYTE) begin
      rbyte_idx_ff <= (rbyte_idx_ff == 3'h5) ? 3'h0 : rbyte_idx_ff + 3'h1;
    end else if (wr && i_paddr == useq_pkg::REG_PC) begin
      rbyte_idx_ff <= 3'h0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_prdata <= 32'h0;
    end else if (i_psel && !i_penable && !i_pwrite) begin
      unique case (i_paddr)
        useq_pkg::REG_CTRL:  o_prdata <= {31'h0, run_ff};
        useq_pkg::REG_PC:    o_prdata <= {20'h0, next_uaddr_ff};
        useq_pkg::REG_WADDR: o_prdata <= {20'h0, waddr_ff};
        useq_pkg::REG_RBYTE: o_prdata <= {24'h0,
          8'(store[next_uaddr_ff[AW-1:0]] >> {rbyte_idx_ff, 3'h0})};
        useq_pkg::REG_STAT:  o_prdata <= {24'h0, click_ff, 1'b0, 3'(phase_ff), run_ff};
        useq_pkg::REG_COND:  o_prdata <= {28'h0, cond_ff};
        default:             o_prdata <= 32'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // machine cycle timing, phases and clicks
  always_ff @(posedge i_clk) begin
    if (i_srst || !run_ff) begin
      tick_ff <= '0;
    end else begin
      tick_ff <= step ? '0 : tick_ff + CW'(1);
    end
  end

  // helper for the cycle length check: clocks since the last step
  always_ff @(posedge i_clk) begin
    if (i_srst || !run_ff) begin
      since_step_ff <= '0;
      stepped_ff    <= 1'b0;
    end else begin
      since_step_ff <= step ? '0 : since_step_ff + CW'(1);
      stepped_ff    <= stepped_ff || step;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      phase_ff <= useq_pkg::PH_ONE;
      click_ff <= 3'h0;
    end else if (step) begin
      unique case (phase_ff)
        useq_pkg::PH_ONE:   phase_ff <= useq_pkg::PH_TWO;
        useq_pkg::PH_TWO:   phase_ff <= useq_pkg::PH_THREE;
        useq_pkg::PH_THREE: begin
          phase_ff <= useq_pkg::PH_ONE;
          click_ff <= (click_ff == 3'(useq_pkg::CLICKS - 1)) ? 3'h0 : click_ff + 3'h1;
        end
        default:            phase_ff <= useq_pkg::PH_ONE;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_emu_task <= 1'b1;
    end else begin
      o_emu_task <= !i_io_req[click_ff];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // next address: goto field, ORed with conditions after a branch
  always_comb begin
    // the word in fetch_ff precedes the one being read, so its branch mode gates the OR
    next_uaddr_inputs = piped_goto_addr |
                        (dif.y_branch_dispatch ? {8'h00, i_cond | cond_ff} : 12'h000);
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      next_uaddr_ff <= 12'h000;
    end else if (wr && i_paddr == useq_pkg::REG_PC && !run_ff) begin
      next_uaddr_ff <= i_pwdata[11:0];
    end else if (step) begin
      next_uaddr_ff <= next_uaddr_inputs;
    end
  end

  // fetch of the successor overlaps execution of the current word
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      fetch_ff <= '0;
    end else if (step) begin
      fetch_ff <= store[next_uaddr_ff[AW-1:0]];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      raw_uinstr_latch_ff <= '0;
    end else if (step) begin
      raw_uinstr_latch_ff <= {fetch_ff[35:24], 4'h0, fetch_ff[19:0]};
    end
  end

  // goto taken straight from the word being read, so the address loop closes in one cycle
  assign fetch_word      = store[next_uaddr_ff[AW-1:0]];
  assign piped_goto_addr = fetch_word[useq_pkg::GOTO_LSB +: useq_pkg::ADDR_W];

  assign dif.sel = fetch_ff[useq_pkg::SEL_LSB +: 4];
  assign dif.fx  = fetch_ff[useq_pkg::FX_LSB +: 4];
  assign dif.fy  = fetch_ff[useq_pkg::FY_LSB +: 4];
  assign dif.fz  = fetch_ff[useq_pkg::FZ_LSB +: 4];

  useq_lookahead u_dec (
    .d (dif)
  );

  ////////////////////////////////////////////////////////////////////
  // decoded command registers, zeroed while halted
  always_ff @(posedge i_clk) begin
    if (i_srst || (step ? 1'b0 : !run_ff)) begin
      o_x_cmd            <= 16'h0;
      o_y_normal_func    <= 4'h0;
      o_z_normal_func    <= 4'h0;
      o_y_io_output_sel  <= 1'b0;
      o_z_io_input_sel   <= 1'b0;
      o_const_byte       <= 8'h0;
      o_carry_in         <= 1'b0;
      o_uregister_enable <= 1'b0;
      o_mem_op           <= 1'b0;
      o_alu_lo           <= 8'h0;
      o_alu_hi           <= 8'h0;
    end else if (step) begin
      o_x_cmd            <= dif.x_cmd;
      o_y_normal_func    <= dif.y_normal_func;
      o_z_normal_func    <= dif.z_normal_func;
      o_y_io_output_sel  <= dif.y_io_output_sel;
      o_z_io_input_sel   <= dif.z_io_input_sel;
      o_const_byte       <= dif.const_byte;
      o_carry_in         <= fetch_ff[useq_pkg::CIN_BIT];
      o_uregister_enable <= fetch_ff[useq_pkg::ENU_BIT];
      o_mem_op           <= fetch_ff[useq_pkg::MEM_BIT];
      o_alu_lo           <= {fetch_ff[useq_pkg::AS_LSB +: 3], fetch_ff[useq_pkg::AF_LSB +: 3],
                             2'b00};
      o_alu_hi           <= {fetch_ff[useq_pkg::AS_LSB +: 3], fetch_ff[useq_pkg::AF_LSB +: 3],
                             2'b01};
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_next_uaddr <= 12'h000;
      o_phase      <= 2'h0;
      o_click      <= 3'h0;
      o_running    <= 1'b0;
    end else begin
      o_next_uaddr <= next_uaddr_ff;
      o_phase      <= 2'(phase_ff);
      o_click      <= click_ff;
      o_running    <= run_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // sequencing checks
  a_phase_order: assert property (@(posedge i_clk) disable iff (i_srst)
    step && phase_ff == useq_pkg::PH_THREE |=> phase_ff == useq_pkg::PH_ONE)
    else $error("phase three not followed by phase one");
  a_click_wrap: assert property (@(posedge i_clk) disable iff (i_srst)
    click_ff <= 3'h4) else $error("click out of range");
  a_click_next: assert property (@(posedge i_clk) disable iff (i_srst)
    step && phase_ff == useq_pkg::PH_THREE |=>
    click_ff == (($past(click_ff) == 3'h4) ? 3'h0 : $past(click_ff) + 3'h1)) else $error("click skipped");
  a_halt_hold: assert property (@(posedge i_clk) disable iff (i_srst)
    !run_ff && !wr |=> $stable(next_uaddr_ff)) else $error("address moved while halted");
  a_halt_nostep: assert property (@(posedge i_clk) disable iff (i_srst)
    !run_ff |-> !step)
    else $error("step while halted");
  a_pc_locked: assert property (@(posedge i_clk) disable iff (i_srst)
    run_ff && !step |=> $stable(next_uaddr_ff))
    else $error("address moved between steps");
  a_branch_or: assert property (@(posedge i_clk) disable iff (i_srst)
    step |=> next_uaddr_ff == $past(next_uaddr_inputs)) else $error("bad next address");
  a_reset_halt: assert property (@(posedge i_clk)
    i_srst |=> !run_ff && phase_ff == useq_pkg::PH_ONE && click_ff == 3'h0)
    else $error("reset state wrong");
  a_cycle_len: assert property (@(posedge i_clk) disable iff (i_srst)
    step && stepped_ff |-> since_step_ff == CW'(useq_pkg::CYCLE_CLKS - 1))
    else $error("machine cycle length wrong");
  a_tick_bound: assert property (@(posedge i_clk) disable iff (i_srst)
    tick_ff <= CW'(useq_pkg::CYCLE_CLKS - 1))
    else $error("cycle counter out of range");
  a_halt_quiet: assert property (@(posedge i_clk) disable iff (i_srst)
    !o_running |-> !o_mem_op && !o_uregister_enable) else $error("side effect while halted");
  a_emu_task: assert property (@(posedge i_clk) disable iff (i_srst)
    !i_io_req[click_ff] |=> o_emu_task) else $error("emulator not run");
  a_x_onehot: assert property (@(posedge i_clk) disable iff (i_srst)
    o_x_cmd == 16'h0 || $onehot(o_x_cmd))
    else $error("x command not one-hot");
  a_alu_split: assert property (@(posedge i_clk) disable iff (i_srst)
    o_alu_lo[7:2] == o_alu_hi[7:2] && o_alu_lo[1:0] == 2'b00)
    else $error("alu halves disagree");

  // bus protocol checks
  a_pready_pulse: assert property (@(posedge i_clk) disable iff (i_srst)
    o_pready |=> !o_pready)
    else $error("pready held two cycles");
  a_err_ready: assert property (@(posedge i_clk) disable iff (i_srst)
    o_pslverr |-> o_pready)
    else $error("error without ready");
endmodule
